// ### rtl/lss_shift_if.sv
/*
 * Serial front end of an eight-channel LED sink driver with a Wishbone
 * status/control port. Assumes all serial pins, the gate, the overtemp
 * indication and the sense lines are asynchronous to MCLK.
 */
// The Wishbone interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
module lss_shift_if
    import lss_pkg::*;
#(
    parameter int TB_CYCLES = LSS_TB_CYCLES,
    parameter int WD_TICKS = LSS_WD_TICKS
) (
    input wire logic MCLK,
    input wire logic RSTN,
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [7:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    input wire logic SCLK,
    input wire logic SDIN,
    input wire logic LATCH_LOAD,
    input wire logic GATE_N,
    input wire logic OVERTEMP,
    input wire logic [7:0] SENSE_OK,
    output logic SDOUT,
    output logic [7:0] LED_SINKS_O,
    output logic [7:0] LED_SINKS_OE
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [LSS_SY_W-1:0] raw;
    logic [LSS_SY_W-1:0] sy1_q;
    logic [LSS_SY_W-1:0] sy2_q;
    logic [LSS_SY_W-1:0] sy3_q;
    logic sclk_rise;
    logic load_rise;
    logic activity;
    logic wd_expire;
    logic [7:0] shift_q;
    logic [7:0] latch_q;
    logic fchk_q;
    logic fault_q;
    logic fault_now;
    logic wd_hold_q;
    logic [1:0] ctrl_q;
    logic [7:0] sink_oe_q;
    logic [7:0] sink_o_q;
    logic ack_q;
    logic [31:0] dat_q;
    logic [31:0] rd_d;
    logic bus_req;
    logic wr_ctrl;

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    assign raw = {SENSE_OK, OVERTEMP, GATE_N, LATCH_LOAD, SDIN, SCLK};

    // Stage one feeds stage two only; edges compare stages two and three
    for (genvar i = 0; i < LSS_SY_W; i++) begin : g_sync
        always_ff @(posedge MCLK) begin
            if (!RSTN) begin
                sy1_q[i] <= 1'b0;
                sy2_q[i] <= 1'b0;
                sy3_q[i] <= 1'b0;
            end else begin
                sy1_q[i] <= raw[i];
                sy2_q[i] <= sy1_q[i];
                sy3_q[i] <= sy2_q[i];
            end
        end
    end

    assign sclk_rise = sy2_q[LSS_SY_SCLK] && !sy3_q[LSS_SY_SCLK];
    assign load_rise = sy2_q[LSS_SY_LOAD] && !sy3_q[LSS_SY_LOAD];
    // Any toggle on clock, data or load counts as activity
    assign activity = |(sy2_q[LSS_SY_LOAD:LSS_SY_SCLK] ^ sy3_q[LSS_SY_LOAD:LSS_SY_SCLK]);

    // ----------------------------------------------------------------
    // Watchdog
    // ----------------------------------------------------------------
    lss_watchdog #(
        .TB_CYCLES(TB_CYCLES),
        .WD_TICKS(WD_TICKS)
    ) u_wd (
        .clk(MCLK),
        .rst_n(RSTN),
        .enable(ctrl_q[LSS_CT_WD_ENABLE]),
        .kick(activity),
        .expire(wd_expire)
    );

    // Hold keeps a still-high load from refilling the latch after timeout
    always_ff @(posedge MCLK) begin
        if (!RSTN || activity) begin
            wd_hold_q <= 1'b0;
        end else if (wd_expire) begin
            wd_hold_q <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Shift register and fault insertion
    // ----------------------------------------------------------------
    always_ff @(posedge MCLK) begin
        if (!RSTN) begin
            shift_q <= 8'h00;
        end else if (sclk_rise) begin
            shift_q <= {shift_q[6:0], sy2_q[LSS_SY_SDIN]};
        end else if (fchk_q) begin
            shift_q[LSS_FAULT_HI] <= fault_now;
            shift_q[LSS_FAULT_LO] <= fault_now;
        end
    end

    // Last stage drives the cascade output directly
    assign SDOUT = shift_q[LSS_NBITS-1];

    // ----------------------------------------------------------------
    // Output latch
    // ----------------------------------------------------------------
    // Stays transparent after fault insertion, so a long load also shows D6/D5
    always_ff @(posedge MCLK) begin
        if (!RSTN) begin
            latch_q <= 8'h00;
        end else if (wd_expire) begin
            latch_q <= 8'h00;
        end else if (sy2_q[LSS_SY_LOAD] && !wd_hold_q) begin
            latch_q <= shift_q;
        end
    end

    // ----------------------------------------------------------------
    // Open-circuit check
    // ----------------------------------------------------------------
    // Checked one cycle after the load edge so the latch already holds new data
    assign fault_now = |(latch_q & ~sy2_q[LSS_SY_SENSE +: LSS_NBITS]);

    always_ff @(posedge MCLK) begin
        if (!RSTN) begin
            fchk_q <= 1'b0;
        end else begin
            fchk_q <= load_rise;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RSTN) begin
            fault_q <= 1'b0;
        end else if (fchk_q) begin
            fault_q <= fault_now;
        end
    end

    // ----------------------------------------------------------------
    // Sink drive
    // ----------------------------------------------------------------
    // Sinks pull low when enabled; blanking never alters stored state
    always_ff @(posedge MCLK) begin
        if (!RSTN) begin
            sink_oe_q <= 8'h00;
            sink_o_q <= 8'h00;
        end else begin
            sink_o_q <= 8'h00;
            sink_oe_q <= latch_q & {8{!sy2_q[LSS_SY_GATE] && !sy2_q[LSS_SY_OTEMP]
                         && !ctrl_q[LSS_CT_SOFT_BLANK]}};
        end
    end

    assign LED_SINKS_OE = sink_oe_q;
    assign LED_SINKS_O = sink_o_q;

    // ----------------------------------------------------------------
    // Wishbone slave
    // ----------------------------------------------------------------
    assign bus_req = CYC_I && STB_I;
    assign wr_ctrl = bus_req && ack_q && WE_I && SEL_I[0] && (ADR_I == LSS_ADR_CTRL);

    always_comb begin
        rd_d = 32'h0000_0000;
        case (ADR_I)
            LSS_ADR_STATUS: begin
                rd_d[LSS_ST_SHIFT_LSB +: 8] = shift_q;
                rd_d[LSS_ST_LATCH_LSB +: 8] = latch_q;
                rd_d[LSS_ST_FAULT] = fault_q;
                rd_d[LSS_ST_WD_HOLD] = wd_hold_q;
                rd_d[LSS_ST_OVERTEMP] = sy2_q[LSS_SY_OTEMP];
                rd_d[LSS_ST_GATE] = sy2_q[LSS_SY_GATE];
            end
            LSS_ADR_CTRL: begin
                rd_d[1:0] = ctrl_q;
            end
            default: begin
                rd_d = 32'h0000_0000;
            end
        endcase
    end

    // Answer one cycle after the request appears; drop it the cycle after
    always_ff @(posedge MCLK) begin
        if (!RSTN) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= bus_req && !ack_q;
            dat_q <= rd_d;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RSTN) begin
            ctrl_q <= LSS_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_q <= DAT_I[1:0];
        end
    end

    assign ACK_O = ack_q;
    assign DAT_O = dat_q;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RSTN);

    shift_in_msb_a: assert property (
        sclk_rise |=> shift_q == {$past(shift_q[6:0]), $past(sy2_q[LSS_SY_SDIN])})
        else $error("shift register did not take serial bit");

    sdout_delay_a: assert property (
        sclk_rise ##1 (!sclk_rise)[*1] |-> SDOUT == $past(shift_q[6]))
        else $error("serial output not the last shift stage");

    latch_follow_a: assert property (
        (sy2_q[LSS_SY_LOAD] && !wd_hold_q && !wd_expire) |=> latch_q == $past(shift_q))
        else $error("latch not transparent while load high");

    latch_hold_a: assert property (
        (!sy2_q[LSS_SY_LOAD] && !wd_expire) |=> $stable(latch_q))
        else $error("latch changed while load low");

    fault_insert_a: assert property (
        (fchk_q && !sclk_rise) |=> shift_q[6:5] == {2{$past(fault_now)}}
        && shift_q[7] == $past(shift_q[7]) && shift_q[4:0] == $past(shift_q[4:0]))
        else $error("fault bits not loaded or other bits disturbed");

    fault_timing_a: assert property (
        load_rise |=> fchk_q ##1 !fchk_q)
        else $error("fault check not one cycle after load edge");

    wd_clear_a: assert property (
        wd_expire |=> latch_q == 8'h00 && shift_q == $past(shift_q) ##1 sink_oe_q == 8'h00)
        else $error("watchdog did not clear latch alone");

    gate_blank_a: assert property (
        (sy2_q[LSS_SY_GATE] || sy2_q[LSS_SY_OTEMP]) |=> sink_oe_q == 8'h00)
        else $error("sinks driven while gated or overheated");

    sink_follow_a: assert property (
        (!sy2_q[LSS_SY_GATE] && !sy2_q[LSS_SY_OTEMP] && !ctrl_q[LSS_CT_SOFT_BLANK])
        |=> sink_oe_q == $past(latch_q))
        else $error("enabled sinks do not follow latch");

    ack_pulse_a: assert property (
        (bus_req && !ack_q) |=> ack_q ##1 !ack_q)
        else $error("bus answer not a single cycle");

endmodule : lss_shift_if

// ### pkg/lss_pkg.sv
/*
 * Shared constants of the LED sink shift interface: register map, field
 * positions, reset values, synchroniser layout and watchdog timing.
 * Assumes a 50 MHz system clock and a 32-bit classic Wishbone register bus.
 */
package lss_pkg;

    // --------------------------------------------------------------
    // Register map (byte addresses)
    // --------------------------------------------------------------
    localparam logic [7:0] LSS_ADR_STATUS = 8'h00;
    localparam logic [7:0] LSS_ADR_CTRL = 8'h04;

    // STATUS fields
    localparam int LSS_ST_SHIFT_LSB = 0;
    localparam int LSS_ST_LATCH_LSB = 8;
    localparam int LSS_ST_FAULT = 16;
    localparam int LSS_ST_WD_HOLD = 17;
    localparam int LSS_ST_OVERTEMP = 18;
    localparam int LSS_ST_GATE = 19;

    // CTRL fields and reset value
    localparam int LSS_CT_SOFT_BLANK = 0;
    localparam int LSS_CT_WD_ENABLE = 1;
    localparam logic [1:0] LSS_CTRL_RST = 2'h2;

    // --------------------------------------------------------------
    // Frame and synchroniser layout
    // --------------------------------------------------------------
    localparam int LSS_NBITS = 8;
    localparam int LSS_FAULT_HI = 6;
    localparam int LSS_FAULT_LO = 5;
    localparam int LSS_SY_SCLK = 0;
    localparam int LSS_SY_SDIN = 1;
    localparam int LSS_SY_LOAD = 2;
    localparam int LSS_SY_GATE = 3;
    localparam int LSS_SY_OTEMP = 4;
    localparam int LSS_SY_SENSE = 5;
    localparam int LSS_SY_W = LSS_SY_SENSE + LSS_NBITS;

    // --------------------------------------------------------------
    // Watchdog timing
    // --------------------------------------------------------------
    localparam longint LSS_CLK_HZ = 64'h0000_0000_02FA_F080;
    localparam longint LSS_WD_TIMEOUT_S = 64'h0000_0000_0000_0001;
    localparam longint LSS_WD_CYCLES = LSS_WD_TIMEOUT_S * LSS_CLK_HZ;
    localparam int LSS_TB_CYCLES = 32'h0000_03E8;
    localparam int LSS_WD_TICKS = int'(LSS_WD_CYCLES / LSS_TB_CYCLES);

endpackage : lss_pkg

// ### rtl/lss_watchdog.sv
/*
 * Idle watchdog: a free-running timebase prescaler and a tick counter.
 * Assumes kick is a one-cycle pulse on serial-line activity, on clk.
 */
`timescale 1ns/1ps
module lss_watchdog
    import lss_pkg::*;
#(
    parameter int TB_CYCLES = LSS_TB_CYCLES,
    parameter int WD_TICKS = LSS_WD_TICKS
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic kick,
    output logic expire
);

    logic [31:0] pre_q;
    logic [31:0] tick_cnt_q;
    logic tick;
    logic armed_q;

    // ----------------------------------------------------------------
    // Timebase runs free of the serial clock
    // ----------------------------------------------------------------
    assign tick = (pre_q == 32'(TB_CYCLES - 1));

    always_ff @(posedge clk) begin
        if (!rst_n || tick) begin
            pre_q <= 32'h0000_0000;
        end else begin
            pre_q <= pre_q + 32'h0000_0001;
        end
    end

    // Fires once per idle spell; re-armed by activity so it never locks up
    always_ff @(posedge clk) begin
        if (!rst_n || kick || !enable) begin
            tick_cnt_q <= 32'h0000_0000;
            armed_q <= 1'b1;
        end else if (tick && armed_q) begin
            if (tick_cnt_q == 32'(WD_TICKS - 1)) begin
                armed_q <= 1'b0;
            end
            tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
        end
    end

    assign expire = tick && armed_q && enable && !kick
                    && (tick_cnt_q == 32'(WD_TICKS - 1));

endmodule : lss_watchdog

// ### tb/lss_host_model.sv
/*
 * Behavioural host controller for the serial side of the LED sink interface.
 * Assumes mclk is the 50 MHz bench clock; SCLK runs at 160 ns inside frames.
 */
`timescale 1ns/1ps
module lss_host_model (
    input wire logic mclk,
    input wire logic sdout,
    output logic sclk,
    output logic sdin,
    output logic latch_load
);
    // ------------------------------------------------------------
    // Frame driver
    // ------------------------------------------------------------
    initial begin
        sclk = 1'b0;
        sdin = 1'b0;
        latch_load = 1'b0;
    end

    // Clock stands low outside frames; data changes half a period before rise
    task automatic send_frame(input logic [7:0] data, output logic [7:0] ret);
        for (int i = 7; i >= 0; i--) begin
            @(posedge mclk);
            sclk <= 1'b0;
            sdin <= data[i];
            repeat (4) @(posedge mclk);
            ret[i] = sdout;
            sclk <= 1'b1;
            repeat (3) @(posedge mclk);
        end
        @(posedge mclk);
        sclk <= 1'b0;
        repeat (4) @(posedge mclk);
        latch_load <= 1'b1;
        repeat (4) @(posedge mclk);
        latch_load <= 1'b0;
        repeat (8) @(posedge mclk);
    endtask : send_frame
endmodule : lss_host_model

// ### tb/tb_top.sv
/*
 * Self-checking bench: Wishbone tasks plus serial frames from the host model.
 * Assumes a shortened watchdog of 40 clock cycles (4 x 10 ticks).
 */
`timescale 1ns/1ps
module tb_top
    import lss_pkg::*;
;
    logic mclk, rstn, cyc, stb, we, ack, sclk, sdin, latch_load, gate_n, otemp, sdout;
    logic [7:0] adr, sense_ok, sinks_o, sinks_oe, ret;
    logic [3:0] sel;
    logic [31:0] dat_i, dat_o, rd;
    int error_cnt = 0;
    int tests_run = 0;

    lss_shift_if #(.TB_CYCLES(4), .WD_TICKS(10)) u_dut (
        .MCLK(mclk), .RSTN(rstn), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr),
        .SEL_I(sel), .DAT_I(dat_i), .DAT_O(dat_o), .ACK_O(ack), .SCLK(sclk),
        .SDIN(sdin), .LATCH_LOAD(latch_load), .GATE_N(gate_n), .OVERTEMP(otemp),
        .SENSE_OK(sense_ok), .SDOUT(sdout), .LED_SINKS_O(sinks_o),
        .LED_SINKS_OE(sinks_oe)
    );

    lss_host_model u_host (
        .mclk(mclk), .sdout(sdout), .sclk(sclk), .sdin(sdin), .latch_load(latch_load)
    );

    always #10 mclk = ~mclk;

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rdat);
        int n;
        n = 0;
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_i <= wd;
        @(posedge mclk);
        while (ack !== 1'b1 && n < 50) begin
            @(posedge mclk);
            n++;
        end
        check("ack", 32'(n < 50), 32'h0000_0001);
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb

    task automatic chk_st(input logic [7:0] sh, input logic [7:0] la, input logic flt);
        logic [31:0] r;
        wb(1'b0, LSS_ADR_STATUS, 32'h0000_0000, r);
        check("shift", 32'(r[7:0]), 32'(sh));
        check("latch", 32'(r[15:8]), 32'(la));
        check("fault", 32'(r[LSS_ST_FAULT]), 32'(flt));
    endtask : chk_st

    task automatic end_of_test;
        if (error_cnt == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_of_test

    task automatic oe_is(input logic [7:0] exp);
        repeat (4) @(posedge mclk);
        check("sinks_oe", 32'(sinks_oe), 32'(exp));
        check("sinks_o", 32'(sinks_o), 32'h0000_0000);
    endtask : oe_is

    // ------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        end_of_test();
    end

    initial begin
        mclk = 1'b0;
        rstn = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'hF;
        dat_i = 32'h0000_0000;
        gate_n = 1'b1;
        otemp = 1'b0;
        sense_ok = 8'hFF;
        repeat (8) @(posedge mclk);
        rstn <= 1'b1;
        oe_is(8'h00);
        check("sdout", 32'(sdout), 32'h0000_0000);
        wb(1'b0, LSS_ADR_STATUS, 32'h0000_0000, rd);
        check("status", rd, 32'h0008_0000);
        wb(1'b1, 8'h08, 32'h0000_0001, rd);
        wb(1'b0, LSS_ADR_CTRL, 32'h0000_0000, rd);
        check("ctrl", rd, 32'(LSS_CTRL_RST));
        wb(1'b0, 8'h08, 32'h0000_0000, rd);
        check("unmapped", rd, 32'h0000_0000);
        wb(1'b1, LSS_ADR_CTRL, 32'h0000_0000, rd);
        wb(1'b0, LSS_ADR_CTRL, 32'h0000_0000, rd);
        check("ctrl_wr", rd, 32'h0000_0000);
        // Gate high while shifting; the transparent latch also takes the fault bits
        u_host.send_frame(8'hA5, ret);
        check("ret0", 32'(ret), 32'h0000_0000);
        chk_st(8'h85, 8'h85, 1'b0);
        oe_is(8'h00);
        gate_n <= 1'b0;
        oe_is(8'h85);
        // Open sink on bit 2, then no commanded sink
        sense_ok <= 8'hFB;
        u_host.send_frame(8'h3C, ret);
        check("ret1", 32'(ret), 32'h0000_0085);
        chk_st(8'h7C, 8'h7C, 1'b1);
        sense_ok <= 8'h00;
        u_host.send_frame(8'h00, ret);
        check("ret2", 32'(ret), 32'h0000_007C);
        check("pair", 32'(ret[6] ^ ret[5]), 32'h0000_0000);
        chk_st(8'h00, 8'h00, 1'b0);
        // One lit sink per frame; only the open sink 3 may report a fault
        sense_ok <= 8'hF7;
        for (int i = 0; i < 8; i++) begin
            u_host.send_frame(8'h01 << i, ret);
            wb(1'b0, LSS_ADR_STATUS, 32'h0000_0000, rd);
            check("locate", 32'(rd[LSS_ST_FAULT]), 32'(i == 3));
        end
        sense_ok <= 8'hFF;
        u_host.send_frame(8'h0F, ret);
        oe_is(8'h0F);
        // Dimming by pulsing the gate pin
        repeat (2) begin
            gate_n <= 1'b1;
            oe_is(8'h00);
            gate_n <= 1'b0;
            oe_is(8'h0F);
        end
        otemp <= 1'b1;
        oe_is(8'h00);
        chk_st(8'h0F, 8'h0F, 1'b0);
        wb(1'b0, LSS_ADR_STATUS, 32'h0000_0000, rd);
        check("otemp", 32'(rd[LSS_ST_OVERTEMP]), 32'h0000_0001);
        otemp <= 1'b0;
        oe_is(8'h0F);
        wb(1'b1, LSS_ADR_CTRL, 32'h0000_0001, rd);
        oe_is(8'h00);
        // Watchdog expiry and recovery
        wb(1'b1, LSS_ADR_CTRL, 32'h0000_0002, rd);
        u_host.send_frame(8'hFF, ret);
        check("sinks_oe", 32'(sinks_oe), 32'h0000_009F);
        repeat (80) @(posedge mclk);
        oe_is(8'h00);
        chk_st(8'h9F, 8'h00, 1'b0);
        wb(1'b0, LSS_ADR_STATUS, 32'h0000_0000, rd);
        check("wd_hold", 32'(rd[LSS_ST_WD_HOLD]), 32'h0000_0001);
        u_host.send_frame(8'h81, ret);
        check("ret3", 32'(ret), 32'h0000_009F);
        check("sinks_oe", 32'(sinks_oe), 32'h0000_0081);
        end_of_test();
    end
endmodule : tb_top
